// ---- phs_defs.svh ----
`ifndef PHS_DEFS_SVH
`define PHS_DEFS_SVH
`define PHS_ADDR_CTRL 8'h00
`define PHS_ADDR_DOUT 8'h04
`define PHS_ADDR_DIN 8'h08
`define PHS_ADDR_CMD 8'h0C
`define PHS_ADDR_STAT 8'h10
`define PHS_ADDR_DELAY 8'h14
`define PHS_CTRL_IN_SENSE 0
`define PHS_CTRL_OUT_SENSE 1
`define PHS_CTRL_REQ_SENSE 2
`define PHS_CTRL_FLAG_SENSE 3
`define PHS_CTRL_PULSE_MODE 4
`define PHS_CTRL_LATCH_LO 5
`define PHS_CTRL_LATCH_HI 6
`define PHS_CTRL_OK_EN 7
`define PHS_CTRL_OK_SENSE 8
`define PHS_CTRL_PRIO_LO 9
`define PHS_CTRL_PRIO_HI 10
`define PHS_CTRL_INT_EN 11
`define PHS_CTRL_W 12
`define PHS_CTRL_RESET 12'h003
`define PHS_CMD_INPUT 0
`define PHS_CMD_SOFT_RST 1
`define PHS_CMD_NEW_SEQ 2
`define PHS_STAT_BUSY 0
`define PHS_STAT_DONE 1
`define PHS_STAT_ERR 2
`define PHS_STAT_CODE_LO 8
`define PHS_STAT_CODE_HI 15
`define PHS_STAT_LVL_LO 16
`define PHS_STAT_LVL_HI 18
`define PHS_STAT_FLAG 19
`define PHS_STAT_OK 20
`define PHS_STAT_EXT_INT 21
`define PHS_STAT_REQ 22
`define PHS_ERR_NOT_OK 8'hAC
`define PHS_PRIO_BASE 3'h3
`define PHS_LATCH_BUSY 2'h0
`define PHS_LATCH_READY 2'h1
`define PHS_DELAY_RESET 8'h01
`define PHS_CLK_NS 20
`define PHS_PRST_NS 15000
`define PHS_PRST_CYC ((`PHS_PRST_NS + `PHS_CLK_NS - 1) / `PHS_CLK_NS)
`define PHS_TMR_W 10
`endif

// ---- phs_pkg.sv ----
package phs_pkg;
	typedef enum logic [6:0] {
		S_RESET = 7'h01,
		S_IDLE = 7'h02,
		S_OKCHK = 7'h04,
		S_WAIT = 7'h08,
		S_SETUP = 7'h10,
		S_REQ = 7'h20,
		S_FIN = 7'h40
	} phs_state_t;
endpackage : phs_pkg

// ---- phs_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module phs_timer #(
	parameter int WIDTH = 10
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic load,
	input wire logic [WIDTH-1:0] loadVal,
	output logic zero
);
	logic [WIDTH-1:0] cnt_reg;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt_reg <= '0;
		end else if (load) begin
			cnt_reg <= loadVal;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	// Zero is registered so that it rises as the count reaches zero.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			zero <= 1'b1;
		end else if (load) begin
			zero <= (loadVal == '0);
		end else begin
			zero <= (cnt_reg[WIDTH-1:1] == '0);
		end
	end
endmodule : phs_timer
`default_nettype wire

// ---- phs_port.sv ----
// Function
// - two bits pick interrupt priority three to six
// - data lines default to low-true sense
// - input sense zero means high-true; both default one
// - direction high for input, low for output
// - request and flag senses selectable independently
// - mode bit picks full or pulse handshake
// - optional OK check aborts with code 172
// - OK check skippable, both modes, selectable sense
// - full mode waits request inactive and flag ready
// - output: data, direction low, delay, then request
// - flag ready-to-busy clears request automatically
// - output data held until ready again (pulse mode: the next word can load while the flag is still busy)
// - latch source: busy edge, ready edge, read
// - busy edge latch captures input lines
// - input word: direction high, then request
// - pulse mode skips flag-ready check
// - reset pulses peripheral reset low 15 us
//
// Decided for this implementation: the address map and the APB slave port.
`include "phs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module phs_port
	import phs_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] inputDataLines,
	output logic [15:0] outputDataLines,
	output logic directionLine,
	output logic transferRequest,
	input wire logic peripheralFlag,
	input wire logic peripheralOkStatus,
	input wire logic externalInterruptRequest,
	output logic peripheralResetLineN
);
	localparam int PRST_MIN = `PHS_PRST_CYC;

	phs_state_t state_reg, stateNext;
	logic [`PHS_CTRL_W-1:0] ctrl_reg;
	logic [15:0] dout_reg, din_reg;
	logic [7:0] delay_reg, errCode_reg;
	logic isOut_reg, reqActive_reg, reqNext, flagPrev_reg;
	logic doneFlag_reg, errFlag_reg, okPending_reg;
	logic prstStart_reg, dlyLoad_reg, prstZero, dlyZero;
	logic [31:0] readMux;
	logic [15:0] sensedIn;
	logic [1:0] latchSel;
	logic setupPh, wrEn, mapped, readDin;
	logic startOut, startIn, softRst, newSeq;
	logic flagReady, busyEdge, readyEdge, okNow, pulseMode;
	logic [2:0] prioLevel;

	// Pin senses: flag ready, OK level and input data follow the control bits.
	// independent flag sense
	assign flagReady = peripheralFlag ^ ctrl_reg[`PHS_CTRL_FLAG_SENSE];
	assign okNow = peripheralOkStatus ^ ctrl_reg[`PHS_CTRL_OK_SENSE];
	assign sensedIn = inputDataLines ^ {16{ctrl_reg[`PHS_CTRL_IN_SENSE]}};
	assign pulseMode = ctrl_reg[`PHS_CTRL_PULSE_MODE];
	assign latchSel = ctrl_reg[`PHS_CTRL_LATCH_HI:`PHS_CTRL_LATCH_LO];
	assign busyEdge = flagPrev_reg & ~flagReady;
	assign readyEdge = ~flagPrev_reg & flagReady;
	assign prioLevel = {1'b0, ctrl_reg[`PHS_CTRL_PRIO_HI:`PHS_CTRL_PRIO_LO]} + `PHS_PRIO_BASE;

	assign setupPh = psel & ~penable;
	assign wrEn = psel & penable & pwrite & pready;
	assign mapped = (paddr == `PHS_ADDR_CTRL) || (paddr == `PHS_ADDR_DOUT) ||
		(paddr == `PHS_ADDR_DIN) || (paddr == `PHS_ADDR_CMD) ||
		(paddr == `PHS_ADDR_STAT) || (paddr == `PHS_ADDR_DELAY);
	assign readDin = setupPh & ~pwrite & (paddr == `PHS_ADDR_DIN);
	assign startOut = wrEn & (paddr == `PHS_ADDR_DOUT) & (state_reg == S_IDLE);
	assign startIn = wrEn & (paddr == `PHS_ADDR_CMD) & pwdata[`PHS_CMD_INPUT] &
		(state_reg == S_IDLE);
	assign softRst = wrEn & (paddr == `PHS_ADDR_CMD) & pwdata[`PHS_CMD_SOFT_RST];
	assign newSeq = wrEn & (((paddr == `PHS_ADDR_CMD) & pwdata[`PHS_CMD_NEW_SEQ]) |
		(paddr == `PHS_ADDR_CTRL));

	phs_timer #(.WIDTH(`PHS_TMR_W)) prstTimer (
		.clk(clk),
		.nrst(nrst),
		.load(prstStart_reg),
		.loadVal(`PHS_TMR_W'(`PHS_PRST_CYC)),
		.zero(prstZero)
	);

	phs_timer #(.WIDTH(`PHS_TMR_W)) dlyTimer (
		.clk(clk),
		.nrst(nrst),
		.load(dlyLoad_reg),
		.loadVal(isOut_reg ? {2'b00, delay_reg} : `PHS_TMR_W'(0)),
		.zero(dlyZero)
	);

	always_comb begin
		stateNext = state_reg;
		unique case (state_reg)
			S_RESET: begin
				if (!prstStart_reg && prstZero) begin
					stateNext = S_IDLE;
				end
			end
			S_IDLE: begin
				if (startOut || startIn) begin
					stateNext = (ctrl_reg[`PHS_CTRL_OK_EN] && okPending_reg) ? S_OKCHK : S_WAIT;
				end
			end
			S_OKCHK: begin
				stateNext = okNow ? S_WAIT : S_IDLE;
			end
			S_WAIT: begin
				if (!reqActive_reg && (pulseMode || flagReady)) begin
					stateNext = S_SETUP;
				end
			end
			S_SETUP: begin
				if (!dlyLoad_reg && dlyZero) begin
					stateNext = S_REQ;
				end
			end
			S_REQ: begin
				if (busyEdge) begin
					stateNext = S_FIN;
				end
			end
			S_FIN: begin
				if (pulseMode || flagReady) begin
					stateNext = S_IDLE;
				end
			end
			default: stateNext = S_RESET;
		endcase
		if (softRst) begin
			stateNext = S_RESET;
		end
	end

	always_comb begin
		reqNext = reqActive_reg;
		if (state_reg == S_SETUP && stateNext == S_REQ) begin
			reqNext = 1'b1;
		end
		if (busyEdge || softRst) begin
			reqNext = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_reg <= S_RESET;
			prstStart_reg <= 1'b1;
			dlyLoad_reg <= 1'b0;
			flagPrev_reg <= 1'b1;
		end else begin
			state_reg <= stateNext;
			prstStart_reg <= softRst;
			dlyLoad_reg <= (state_reg == S_WAIT) && (stateNext == S_SETUP);
			flagPrev_reg <= flagReady;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			peripheralResetLineN <= 1'b0;
		end else begin
			peripheralResetLineN <= (stateNext != S_RESET);
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			reqActive_reg <= 1'b0;
			transferRequest <= 1'b0;
		end else begin
			reqActive_reg <= reqNext;
			transferRequest <= reqNext ^ ctrl_reg[`PHS_CTRL_REQ_SENSE];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			isOut_reg <= 1'b1;
			directionLine <= 1'b0;
			outputDataLines <= 16'hFFFF;
		end else begin
			if (startOut || startIn) begin
				isOut_reg <= startOut;
			end
			if (state_reg == S_WAIT && stateNext == S_SETUP) begin
				directionLine <= ~isOut_reg;
				if (isOut_reg) begin
					outputDataLines <= dout_reg ^ {16{ctrl_reg[`PHS_CTRL_OUT_SENSE]}};
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			din_reg <= 16'h0000;
		end else if ((latchSel == `PHS_LATCH_BUSY && busyEdge) ||
			(latchSel == `PHS_LATCH_READY && readyEdge) ||
			(latchSel[1] && readDin)) begin
			din_reg <= sensedIn;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			okPending_reg <= 1'b1;
			errFlag_reg <= 1'b0;
			errCode_reg <= 8'h00;
			doneFlag_reg <= 1'b0;
		end else begin
			if (softRst || newSeq) begin
				okPending_reg <= 1'b1;
			end else if (state_reg == S_OKCHK && okNow) begin
				okPending_reg <= 1'b0;
			end
			if (state_reg == S_OKCHK && !okNow) begin
				errFlag_reg <= 1'b1;
				errCode_reg <= `PHS_ERR_NOT_OK;
			end else if (wrEn && paddr == `PHS_ADDR_STAT && pwdata[`PHS_STAT_ERR]) begin
				errFlag_reg <= 1'b0;
			end
			if (state_reg == S_FIN && stateNext == S_IDLE) begin
				doneFlag_reg <= 1'b1;
			end else if (wrEn && paddr == `PHS_ADDR_STAT && pwdata[`PHS_STAT_DONE]) begin
				doneFlag_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl_reg <= `PHS_CTRL_RESET;
			dout_reg <= 16'h0000;
			delay_reg <= `PHS_DELAY_RESET;
		end else begin
			if (wrEn && paddr == `PHS_ADDR_CTRL) begin
				ctrl_reg <= pwdata[`PHS_CTRL_W-1:0];
			end else if (softRst) begin
				ctrl_reg[`PHS_CTRL_INT_EN] <= 1'b0;
			end
			if (startOut) begin
				dout_reg <= pwdata[15:0];
			end
			if (wrEn && paddr == `PHS_ADDR_DELAY) begin
				delay_reg <= pwdata[7:0];
			end
		end
	end

	always_comb begin
		readMux = 32'h0000_0000;
		unique case (paddr)
			`PHS_ADDR_CTRL: readMux[`PHS_CTRL_W-1:0] = ctrl_reg;
			`PHS_ADDR_DOUT: readMux[15:0] = dout_reg;
			`PHS_ADDR_DIN: readMux[15:0] = latchSel[1] ? sensedIn : din_reg;
			`PHS_ADDR_STAT: begin
				readMux[`PHS_STAT_BUSY] = (state_reg != S_IDLE);
				readMux[`PHS_STAT_DONE] = doneFlag_reg;
				readMux[`PHS_STAT_ERR] = errFlag_reg;
				readMux[`PHS_STAT_CODE_HI:`PHS_STAT_CODE_LO] = errCode_reg;
				readMux[`PHS_STAT_LVL_HI:`PHS_STAT_LVL_LO] = prioLevel;
				readMux[`PHS_STAT_FLAG] = flagReady;
				readMux[`PHS_STAT_OK] = okNow;
				readMux[`PHS_STAT_EXT_INT] = externalInterruptRequest &
					ctrl_reg[`PHS_CTRL_INT_EN];
				readMux[`PHS_STAT_REQ] = reqActive_reg;
			end
			`PHS_ADDR_DELAY: readMux[7:0] = delay_reg;
			default: readMux = 32'h0000_0000;
		endcase
	end

	// Read data and error are prepared in the setup phase; the slave never waits.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready <= 1'b1;
		end else begin
			pready <= 1'b1;
			if (setupPh) begin
				prdata <= readMux;
				pslverr <= ~mapped;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence sOkFail;
		state_reg == S_OKCHK && !okNow && !softRst;
	endsequence

	sequence sBusyInReq;
		state_reg == S_REQ && busyEdge && !softRst;
	endsequence

	a_ok_abort: assert property (sOkFail |=>
		errFlag_reg && errCode_reg == `PHS_ERR_NOT_OK && state_reg == S_IDLE)
		else $error("OK check failure did not abort with code");

	a_ok_skip: assert property (
		state_reg == S_IDLE && (startOut || startIn) && !ctrl_reg[`PHS_CTRL_OK_EN] && !softRst
		|=> state_reg == S_WAIT)
		else $error("disabled OK check was not skipped");

	a_req_clear: assert property (sBusyInReq |=> !reqActive_reg ##0
		transferRequest == ctrl_reg[`PHS_CTRL_REQ_SENSE] ##0 state_reg == S_FIN)
		else $error("busy edge did not clear request");

	a_full_stall: assert property (
		state_reg == S_WAIT && !pulseMode && !flagReady && !softRst |=> state_reg == S_WAIT)
		else $error("full mode left wait without flag ready");

	a_pulse_go: assert property (
		state_reg == S_WAIT && pulseMode && !reqActive_reg && !softRst |=> state_reg == S_SETUP)
		else $error("pulse mode did not skip flag check");

	a_out_dir: assert property ($rose(reqActive_reg) && isOut_reg |->
		!directionLine && $past(state_reg) == S_SETUP && $past(dlyZero))
		else $error("output request raised without direction low and delay");

	a_in_dir: assert property ($rose(reqActive_reg) && !isOut_reg |->
		directionLine && $past(directionLine))
		else $error("input request raised before direction high");

	a_dout_hold: assert property (
		(state_reg == S_REQ || state_reg == S_FIN) && isOut_reg |=> $stable(outputDataLines))
		else $error("output data changed during handshake");

	a_busy_latch: assert property (
		latchSel == `PHS_LATCH_BUSY && busyEdge |=> din_reg == $past(sensedIn))
		else $error("busy edge did not latch input data");

	a_din_hold: assert property (
		!busyEdge && !readyEdge && !readDin |=> $stable(din_reg))
		else $error("input register changed without capture");

	a_prio_range: assert property (
		prioLevel >= 3'h3 && prioLevel <= 3'h6)
		else $error("priority level out of range");

	logic [`PHS_TMR_W-1:0] prstLowCnt;
	always_ff @(posedge clk) begin
		if (!nrst || peripheralResetLineN) begin
			prstLowCnt <= '0;
		end else if (prstLowCnt != '1) begin
			prstLowCnt <= prstLowCnt + 1'b1;
		end
	end

	a_prst_len: assert property ($rose(peripheralResetLineN) |->
		$past(prstLowCnt) >= PRST_MIN - 1)
		else $error("peripheral reset pulse too short");
endmodule : phs_port
`default_nettype wire

// ---- phs_periph_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module phs_periph_model (
	input wire logic clk,
	input wire logic transferRequest,
	input wire logic directionLine,
	input wire logic [15:0] outputDataLines,
	input wire logic reqSense,
	input wire logic flagSense,
	input wire logic pulseMode,
	input wire logic present,
	input wire logic [15:0] inWord,
	input wire logic [4:0] slow,
	output logic peripheralFlag,
	output logic [15:0] inputDataLines,
	output logic [15:0] gotWord,
	output logic gotStrobe
);
	logic flagRdy;
	logic drive;
	logic actQ;
	logic act;
	logic [15:0] junk;
	assign act = transferRequest ^ reqSense;
	assign peripheralFlag = flagRdy ^ flagSense;
	// Released data lines show a pattern that changes every cycle.
	assign inputDataLines = (drive || present) ? inWord : junk;
	initial begin
		flagRdy = 1'b1;
		drive = 1'b0;
		junk = 16'h5A3C;
		gotStrobe = 1'b0;
		gotWord = 16'h0000;
		actQ = 1'b0;
	end
	always @(posedge clk) begin
		junk <= junk + 16'h1357;
		actQ <= act;
	end
	// A request must be seen on two edges, so a sense change cannot start a word.
	always begin
		@(posedge clk);
		if (act && actQ) begin
			drive <= directionLine;
			if (pulseMode) begin
				gotWord <= outputDataLines;
			end
			repeat (slow + 1) @(posedge clk);
			flagRdy <= 1'b0;
			while (act) @(posedge clk);
			repeat (slow) @(posedge clk);
			if (!pulseMode) begin
				gotWord <= outputDataLines;
			end
			gotStrobe <= !directionLine;
			flagRdy <= 1'b1;
			@(posedge clk);
			gotStrobe <= 1'b0;
			drive <= 1'b0;
		end
	end
endmodule : phs_periph_model
`default_nettype wire

// ---- phs_port_tb.sv ----
`include "phs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module phs_port_tb;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic err; logic chk;} phs_exp_t;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rnd, q;
	logic [15:0] inputDataLines, outputDataLines, mInWord, gotWord;
	logic directionLine, transferRequest, peripheralFlag, peripheralOkStatus;
	logic externalInterruptRequest, peripheralResetLineN, gotStrobe;
	logic mReqSense, mFlagSense, mPulse, mPresent;
	logic [4:0] mSlow;
	int num_errors, samples_checked, i, n;
	phs_exp_t expQ[$];
	logic [15:0] perQ[$];
	phs_port dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.inputDataLines(inputDataLines), .outputDataLines(outputDataLines),
		.directionLine(directionLine), .transferRequest(transferRequest),
		.peripheralFlag(peripheralFlag), .peripheralOkStatus(peripheralOkStatus),
		.externalInterruptRequest(externalInterruptRequest),
		.peripheralResetLineN(peripheralResetLineN));
	phs_periph_model pm (.clk(clk), .transferRequest(transferRequest),
		.directionLine(directionLine), .outputDataLines(outputDataLines), .reqSense(mReqSense),
		.flagSense(mFlagSense), .pulseMode(mPulse), .present(mPresent), .inWord(mInWord),
		.slow(mSlow), .peripheralFlag(peripheralFlag), .inputDataLines(inputDataLines),
		.gotWord(gotWord), .gotStrobe(gotStrobe));
	always #10 clk = ~clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic fail(input string msg);
		num_errors++;
		$display("CHECK FAILED at %0t: %s", $time, msg);
	endtask : fail
	task automatic close_out;
		$display("checked %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic err = 1'b0);
		expQ.push_back('{e, m, err, 1'b1});
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic idle;
		int k;
		k = 0;
		do begin
			expQ.push_back('{32'h0, 32'h0, 1'b0, 1'b0});
			apb(1'b0, `PHS_ADDR_STAT, 32'h0);
			k++;
		end while (q[0] !== 1'b0 && k < 300);
		if (k >= 300) fail("transfer hung");
	endtask : idle
	task automatic outWord(input logic [15:0] e);
		rnd = lfsr(rnd);
		perQ.push_back(e ^ rnd[15:0]);
		apb(1'b1, `PHS_ADDR_DOUT, rnd);
		idle();
	endtask : outWord
	always @(posedge clk) begin
		phs_exp_t e;
		if (psel && penable && pready && !pwrite) begin
			e = expQ.pop_front();
			if (e.chk) begin
				samples_checked++;
				if ((prdata & e.m) !== (e.d & e.m) || pslverr !== e.err) fail("read data");
			end
		end
		if (gotStrobe === 1'b1) begin
			samples_checked++;
			if (perQ.size() == 0) fail("unexpected word");
			else if (gotWord !== perQ.pop_front()) fail("peripheral word");
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail("timeout");
		close_out();
	end
	initial begin
		{clk, nrst, psel, penable, pwrite, paddr, pwdata, peripheralOkStatus} = '0;
		{externalInterruptRequest, mReqSense, mFlagSense, mPulse, mPresent, mInWord} = '0;
		mSlow = 5'h02;
		rnd = 32'h82AB;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		n = 0;
		while (peripheralResetLineN !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		samples_checked++;
		if (n < `PHS_PRST_CYC || n >= 2000 || transferRequest !== 1'b0) fail("reset pulse");
		rd(`PHS_ADDR_CTRL, 32'h003, 32'hFFFFFFFF);
		rd(`PHS_ADDR_DELAY, 32'h001, 32'hFFFFFFFF);
		rd(8'h18, 32'h0, 32'hFFFFFFFF, 1'b1);
		for (i = 0; i < 4; i++) begin
			externalInterruptRequest <= i[1];
			apb(1'b1, `PHS_ADDR_CTRL, {i[0], i[1:0], 9'h003});
			rd(`PHS_ADDR_STAT, (32'(i) + 3) << 16 | 32'(i[0] & i[1]) << 21, 32'h00270000);
		end
		// Soft reset: the peripheral reset pulse repeats and the interrupt enable is cleared.
		apb(1'b1, `PHS_ADDR_CMD, 32'h2);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (peripheralResetLineN !== 1'b1 && n < 2000);
		samples_checked++;
		if (n < `PHS_PRST_CYC || n >= 2000 || transferRequest !== 1'b0) fail("soft reset pulse");
		rd(`PHS_ADDR_CTRL, 32'h603, 32'hFFF);
		$display("test registers done");
		for (i = 0; i < 2; i++) begin
			apb(1'b1, `PHS_ADDR_CTRL, i ? 32'h001 : 32'h003);
			outWord(i ? 16'h0000 : 16'hFFFF);
			samples_checked++;
			if (directionLine !== 1'b0) fail("output direction");
		end
		for (i = 0; i < 3; i++) begin
			apb(1'b1, `PHS_ADDR_CTRL, {i[1:0], 5'h02} | (i == 1 ? 32'h0 : 32'h1));
			rnd = lfsr(rnd);
			mInWord <= rnd[15:0];
			mPresent <= (i == 2);
			if (i < 2) apb(1'b1, `PHS_ADDR_CMD, 32'h1);
			if (i < 2) idle();
			samples_checked++;
			if (i < 2 && directionLine !== 1'b1) fail("input direction");
			rd(`PHS_ADDR_DIN, (i == 1) ? rnd[15:0] : ~rnd[15:0], 32'hFFFF);
			mPresent <= 1'b0;
			rd(`PHS_ADDR_DIN, (i == 1) ? rnd[15:0] : ~rnd[15:0], (i < 2) ? 32'hFFFF : 32'h0);
		end
		$display("test data words done");
		apb(1'b1, `PHS_ADDR_CTRL, 32'h083);
		apb(1'b1, `PHS_ADDR_DOUT, 32'h1234);
		idle();
		rd(`PHS_ADDR_STAT, 32'h0000AC04, 32'h0000FF05);
		apb(1'b1, `PHS_ADDR_STAT, 32'h6);
		rd(`PHS_ADDR_STAT, 32'h0000AC00, 32'h0000FF07);
		apb(1'b1, `PHS_ADDR_CTRL, 32'h183);
		outWord(16'hFFFF);
		$display("test ok check done");
		mSlow <= 5'h14;
		mPulse <= 1'b1;
		apb(1'b1, `PHS_ADDR_CTRL, 32'h013);
		for (i = 0; i < 2; i++) begin
			outWord(16'hFFFF);
			rd(`PHS_ADDR_STAT, 32'h0, 32'h00080001);
		end
		repeat (80) @(posedge clk);
		$display("test pulse mode done");
		mSlow <= 5'h01;
		mPulse <= 1'b0;
		apb(1'b1, `PHS_ADDR_CTRL, 32'h00F);
		mReqSense <= 1'b1;
		mFlagSense <= 1'b1;
		outWord(16'hFFFF);
		repeat (10) @(posedge clk);
		$display("test line senses done");
		close_out();
	end
endmodule : phs_port_tb
`default_nettype wire
